// ---- design/cst_block.sv ----
// cyclic-sense timers, wake filters and their register file
// =============================================================================
// Summary of operation
// - filter code 00 accepts a wake level after 16 us of stability.
// - filter code 01 accepts a wake level after 64 us of stability.
// - filter code 10 samples cyclically over 16 us ending each first-timer on-time.
// - filter code 11 samples cyclically over 16 us ending each second-timer on-time.
// - filter register holds three 2-bit selects in bits 5:0; bits 7:6 read zero.
// - on-time bits 6:4 select 0.1, 0.3, 1, 10 or 20 ms.
// - on-time code 000 stops the timer, controlled outputs low; 111 reserved.
// - on-time code 110 stops the timer, controlled outputs high.
// - period bits 2:0 select 10 ms up to 2 s; 111 reserved.
// - second timer register mirrors the first timer's layout and encodings.
// - timer starts by itself once a running on-time code is written.
// - restart with cyclic sensing clears both timers' period and on-time.
// - cyclic wake and cyclic sensing run together when both are enabled.
// - restart clears filter bits 7:6 and keeps the filter fields.
// - power-on, soft reset and restart zero both timer registers.
// - wake control bit 6 and 7 make the timers cyclic wake sources.
// - high-side code 010 follows the first timer, 011 the second.
// =============================================================================
`timescale 1ns/10ps
`default_nettype none

module cst_block #(
    parameter int TICK_CYCLES = cst_pkg::TICK_CYCLES,   // clocks per time base tick
    parameter int NUM_HS      = 4,
    parameter int NUM_WAKE    = 3
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    // register access from the serial interface decoder
    input  wire logic                  reg_wr_en,
    input  wire logic                  reg_rd_en,
    input  wire logic [6:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rd_data,
    // device mode events
    input  wire logic                  soft_reset,
    input  wire logic                  restart_state,
    // wake control bits and high-side configuration
    input  wire logic                  first_timer_wake_source_en,
    input  wire logic                  second_timer_wake_source_en,
    input  wire logic [NUM_HS*3-1:0]   high_side_cfg,
    // wake pins
    input  wire logic [NUM_WAKE-1:0]   wake_in,
    // results
    output logic                       first_timer_pulse,
    output logic                       second_timer_pulse,
    output logic      [NUM_HS-1:0]     high_side_output,
    output logic      [NUM_WAKE-1:0]   wake_level,
    output logic      [1:0]            timer_wake_evt
);

    // =========================================================================
    // elaboration checks
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end
    if (NUM_WAKE != 3) begin : g_bad_wake
        $error("filter register serves exactly three wake inputs");
    end
    // the follow check below watches high-side output two
    if (NUM_HS < 3) begin : g_bad_hs
        $error("NUM_HS must be at least three");
    end

    localparam int DIV_W = 16;

    // =========================================================================
    // block state
    typedef struct packed {
        logic [DIV_W-1:0]              div;
        logic                          tick;
        logic [cst_pkg::FLT_ALL_W-1:0] flt;
        logic [2:0]                    t1_on;
        logic [2:0]                    t1_per;
        logic [2:0]                    t2_on;
        logic [2:0]                    t2_per;
        logic [7:0]                    rd_data;
        logic [NUM_HS-1:0]             hs_drv;
        logic [1:0]                    wake_evt;
    } cst_block_state_type;

    cst_block_state_type s_r;
    cst_block_state_type s_nxt;

    logic [1:0]          win;
    logic [1:0]          win_end;
    logic                pulse_one;
    logic                pulse_two;
    logic [7:0]          rd_mux;

    // =========================================================================
    // timers; the second one shares the layout of the first
    cst_timer u_timer_one (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .tick      (s_r.tick),
        .on_code   (s_r.t1_on),
        .per_code  (s_r.t1_per),
        .pulse     (pulse_one),
        .sense_win (win[0]),
        .sense_end (win_end[0])
    );

    cst_timer u_timer_two (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .tick      (s_r.tick),
        .on_code   (s_r.t2_on),
        .per_code  (s_r.t2_per),
        .pulse     (pulse_two),
        .sense_win (win[1]),
        .sense_end (win_end[1])
    );

    // =========================================================================
    // wake filters, one per input, all on the same tick as the timers
    for (genvar i = 0; i < NUM_WAKE; i++) begin : g_filt
        cst_wake_filter u_filt (
            .clk_sys  (clk_sys),
            .reset_n  (reset_n),
            .tick     (s_r.tick),
            .win      (win),
            .win_end  (win_end),
            .wake_raw (wake_in[i]),
            .mode     (s_r.flt[i*cst_pkg::FLT_FIELD_W +: cst_pkg::FLT_FIELD_W]),
            .level    (wake_level[i])
        );
    end

    // =========================================================================
    // read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            cst_pkg::ADDR_WAKE_FILTER: begin
                rd_mux[cst_pkg::FLT_ALL_W-1:0] = s_r.flt;
            end
            cst_pkg::ADDR_FIRST_TIMER: begin
                rd_mux[cst_pkg::ON_LSB +: cst_pkg::CODE_W]  = s_r.t1_on;
                rd_mux[cst_pkg::PER_LSB +: cst_pkg::CODE_W] = s_r.t1_per;
            end
            cst_pkg::ADDR_SECOND_TIMER: begin
                rd_mux[cst_pkg::ON_LSB +: cst_pkg::CODE_W]  = s_r.t2_on;
                rd_mux[cst_pkg::PER_LSB +: cst_pkg::CODE_W] = s_r.t2_per;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // =========================================================================
    // next state: divider, register writes, restart, outputs
    always_comb begin
        logic [2:0] code;
        code  = 3'h0;
        s_nxt = s_r;

        // divider makes the 1 us tick as a one-cycle enable
        if (s_r.div >= DIV_W'(TICK_CYCLES - 1)) begin
            s_nxt.div  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div  = s_r.div + DIV_W'(1);
            s_nxt.tick = 1'b0;
        end

        // register writes; a new running on-time starts its timer at once
        if (reg_wr_en) begin
            unique case (reg_addr)
                cst_pkg::ADDR_WAKE_FILTER: begin
                    s_nxt.flt = reg_wdata[cst_pkg::FLT_ALL_W-1:0];
                end
                cst_pkg::ADDR_FIRST_TIMER: begin
                    s_nxt.t1_on  = reg_wdata[cst_pkg::ON_LSB +: cst_pkg::CODE_W];
                    s_nxt.t1_per = reg_wdata[cst_pkg::PER_LSB +: cst_pkg::CODE_W];
                end
                cst_pkg::ADDR_SECOND_TIMER: begin
                    s_nxt.t2_on  = reg_wdata[cst_pkg::ON_LSB +: cst_pkg::CODE_W];
                    s_nxt.t2_per = reg_wdata[cst_pkg::PER_LSB +: cst_pkg::CODE_W];
                end
                default: begin
                    s_nxt.flt = s_r.flt;
                end
            endcase
        end

        // restart wins over a write in the same cycle; high-side outputs are not
        // cleared then, they only fall one cycle after the stopped timers' pulses fall
        if (restart_state) begin
            s_nxt.t1_on  = 3'h0;
            s_nxt.t1_per = 3'h0;
            s_nxt.t2_on  = 3'h0;
            s_nxt.t2_per = 3'h0;
            s_nxt.flt    = s_r.flt;
        end

        // soft reset zeroes the filter and timer registers as power-on does
        if (soft_reset) begin
            s_nxt.flt    = '0;
            s_nxt.t1_on  = 3'h0;
            s_nxt.t1_per = 3'h0;
            s_nxt.t2_on  = 3'h0;
            s_nxt.t2_per = 3'h0;
        end

        // registered read answer, valid the cycle after the strobe
        if (reg_rd_en) begin
            s_nxt.rd_data = rd_mux;
        end

        // high-side outputs assigned to a timer follow its pulse
        for (int i = 0; i < NUM_HS; i++) begin
            code = high_side_cfg[i*3 +: 3];
            s_nxt.hs_drv[i] = ((code == cst_pkg::HS_BY_FIRST)  && pulse_one) ||
                              ((code == cst_pkg::HS_BY_SECOND) && pulse_two);
        end

        // cyclic wake events run beside cyclic sensing, independent of it
        s_nxt.wake_evt[0] = win_end[0] && first_timer_wake_source_en;
        s_nxt.wake_evt[1] = win_end[1] && second_timer_wake_source_en;
    end

    // synchronous reset returns every register to its power-on value
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rd_data        = s_r.rd_data;
    assign first_timer_pulse  = pulse_one;
    assign second_timer_pulse = pulse_two;
    assign high_side_output   = s_r.hs_drv;
    assign timer_wake_evt     = s_r.wake_evt;

    // =========================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence seq_start_write;
        reg_wr_en && (reg_addr == cst_pkg::ADDR_FIRST_TIMER) &&
        (reg_wdata[6:4] == 3'h1) && (reg_wdata[2:0] == 3'h0) &&
        !restart_state && !soft_reset;
    endsequence

    sequence seq_pulse_rises;
        ##2 first_timer_pulse ##1 first_timer_pulse;
    endsequence

    auto_start_a: assert property (seq_start_write |-> seq_pulse_rises)
        else $error("timer did not start after on-time write");

    filter_read_a: assert property (
        (reg_rd_en && (reg_addr == cst_pkg::ADDR_WAKE_FILTER)) |=> (reg_rd_data[7:6] == 2'h0))
        else $error("filter register upper bits not zero");

    restart_clear_a: assert property (
        restart_state |=> (s_r.t1_on == 3'h0) && (s_r.t1_per == 3'h0) &&
                          (s_r.t2_on == 3'h0) && (s_r.t2_per == 3'h0))
        else $error("timer fields survive restart");

    restart_keep_a: assert property (
        (restart_state && !soft_reset) |=> (s_r.flt == $past(s_r.flt)))
        else $error("filter fields lost on restart");

    stop_low_a: assert property ((s_r.t1_on == cst_pkg::ON_OFF_LOW) [*2] |-> !first_timer_pulse)
        else $error("stopped timer pulse not low");

    stop_high_a: assert property ((s_r.t2_on == cst_pkg::ON_OFF_HIGH) [*2] |-> second_timer_pulse)
        else $error("stopped timer pulse not high");

    hs_follow_a: assert property (
        (high_side_cfg[8:6] == cst_pkg::HS_BY_SECOND) |=> (high_side_output[2] == $past(pulse_two)))
        else $error("high-side output not following second timer");

    wake_event_a: assert property (
        (win_end[0] && first_timer_wake_source_en) |=> timer_wake_evt[0] ##1 !timer_wake_evt[0])
        else $error("cyclic wake event missing or too long");

    tick_rate_a: assert property ($rose(s_r.tick) |=> !s_r.tick [*1] or (TICK_CYCLES == 1))
        else $error("time base tick longer than one cycle");

endmodule

`default_nettype wire

// ---- design/cst_pkg.sv ----
// constants, codes and timing tables shared by the cyclic-sense timer block
package cst_pkg;

    // =========================================================================
    // time base
    localparam int CLK_PERIOD_NS = 25;        // 40 MHz system clock
    localparam int TICK_NS       = 1000;      // common 1 us time base
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_SHORT_US = 16;        // static and cyclic filter time
    localparam int FILT_LONG_US  = 64;        // long static filter time
    localparam int CNT_W         = 21;        // holds 2 s in microseconds
    localparam int STAB_W        = 7;         // stability counter, holds 64

    // =========================================================================
    // register map, reset values and field layout
    localparam logic [6:0] ADDR_WAKE_FILTER  = 7'h09;
    localparam logic [6:0] ADDR_FIRST_TIMER  = 7'h0c;
    localparam logic [6:0] ADDR_SECOND_TIMER = 7'h0d;
    localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
    localparam int         FLT_FIELD_W       = 2;
    localparam int         FLT_ALL_W         = 6;     // bits 5:0, 7:6 read zero
    localparam int         CODE_W            = 3;
    localparam int         ON_LSB            = 4;     // on-time in bits 6:4
    localparam int         PER_LSB           = 0;     // period in bits 2:0

    // =========================================================================
    // encodings
    localparam logic [2:0] ON_OFF_LOW    = 3'h0;
    localparam logic [2:0] ON_OFF_HIGH   = 3'h6;
    localparam logic [1:0] FLT_STATIC16  = 2'h0;
    localparam logic [1:0] FLT_STATIC64  = 2'h1;
    localparam logic [1:0] FLT_CYC_ONE   = 2'h2;
    localparam logic [1:0] FLT_CYC_TWO   = 2'h3;
    localparam logic [2:0] HS_BY_FIRST   = 3'h2;
    localparam logic [2:0] HS_BY_SECOND  = 3'h3;

    typedef logic [CNT_W-1:0] cst_us_type;

    // on-time in microseconds; zero marks a code that does not run
    function automatic cst_us_type on_time_us(input logic [2:0] code);
        unique case (code)
            3'h1:    on_time_us = cst_us_type'(100);
            3'h2:    on_time_us = cst_us_type'(300);
            3'h3:    on_time_us = cst_us_type'(1000);
            3'h4:    on_time_us = cst_us_type'(10000);
            3'h5:    on_time_us = cst_us_type'(20000);
            default: on_time_us = '0;
        endcase
    endfunction

    // period in microseconds; the reserved code gives zero and stops the timer
    function automatic cst_us_type period_us(input logic [2:0] code);
        unique case (code)
            3'h0:    period_us = cst_us_type'(10000);
            3'h1:    period_us = cst_us_type'(20000);
            3'h2:    period_us = cst_us_type'(50000);
            3'h3:    period_us = cst_us_type'(100000);
            3'h4:    period_us = cst_us_type'(200000);
            3'h5:    period_us = cst_us_type'(1000000);
            3'h6:    period_us = cst_us_type'(2000000);
            default: period_us = '0;
        endcase
    endfunction

endpackage

// ---- design/cst_timer.sv ----
// one cyclic-sense timer: periodic on-time pulse and end-of-on-time sense window
`timescale 1ns/10ps
`default_nettype none

module cst_timer (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // time base
    input  wire logic       tick,
    // settings
    input  wire logic [2:0] on_code,
    input  wire logic [2:0] per_code,
    // results
    output logic            pulse,
    output logic            sense_win,
    output logic            sense_end
);

    typedef struct packed {
        cst_pkg::cst_us_type cnt;
        logic                pulse;
    } cst_timer_state_type;

    cst_timer_state_type s_r;
    cst_timer_state_type s_nxt;
    cst_pkg::cst_us_type on_us;
    cst_pkg::cst_us_type per_us;
    logic                running;

    assign on_us   = cst_pkg::on_time_us(on_code);
    assign per_us  = cst_pkg::period_us(per_code);
    assign running = (on_us != '0) && (per_us != '0);

    // sense window covers the last 16 us of every on-time
    assign sense_win = running && (s_r.cnt < on_us) &&
                       (s_r.cnt >= on_us - cst_pkg::cst_us_type'(cst_pkg::FILT_SHORT_US));
    assign sense_end = running && tick && (s_r.cnt == on_us - cst_pkg::cst_us_type'(1));
    assign pulse     = s_r.pulse;

    // counter restarts from zero whenever a running code appears
    always_comb begin
        s_nxt = s_r;
        if (!running) begin
            s_nxt.cnt   = '0;
            s_nxt.pulse = (on_code == cst_pkg::ON_OFF_HIGH);
        end else begin
            s_nxt.pulse = (s_r.cnt < on_us);
            if (tick) begin
                if (s_r.cnt >= per_us - cst_pkg::cst_us_type'(1)) begin
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + cst_pkg::cst_us_type'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // the counter never reaches the selected period
    period_wrap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        running |-> s_r.cnt < per_us) else $error("timer count beyond period");

endmodule

`default_nettype wire

// ---- design/cst_wake_filter.sv ----
// one wake input filter: static 16/64 us or cyclic sampling in a timer window
`timescale 1ns/10ps
`default_nettype none

module cst_wake_filter (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // time base and sense windows of both timers
    input  wire logic       tick,
    input  wire logic [1:0] win,
    input  wire logic [1:0] win_end,
    // input and setting
    input  wire logic       wake_raw,
    input  wire logic [1:0] mode,
    // filtered level
    output logic            level
);

    typedef struct packed {
        logic                      cand;
        logic [cst_pkg::STAB_W-1:0] cnt;
        logic                      level;
    } cst_filt_state_type;

    cst_filt_state_type s_r;
    cst_filt_state_type s_nxt;
    logic                       cyclic;
    logic                       sel_win;
    logic                       sel_end;
    logic [cst_pkg::STAB_W-1:0] need;

    assign cyclic  = mode[1];
    assign sel_win = mode[0] ? win[1] : win[0];
    assign sel_end = mode[0] ? win_end[1] : win_end[0];
    assign need    = (mode == cst_pkg::FLT_STATIC64) ?
                     cst_pkg::STAB_W'(cst_pkg::FILT_LONG_US) :
                     cst_pkg::STAB_W'(cst_pkg::FILT_SHORT_US);
    assign level   = s_r.level;

    // count ticks of unchanged input; cyclic mode only counts inside the window
    always_comb begin
        s_nxt = s_r;
        if (cyclic && !sel_win) begin
            s_nxt.cand = wake_raw;
            s_nxt.cnt  = '0;
        end else if (tick) begin
            if (wake_raw != s_r.cand) begin
                s_nxt.cand = wake_raw;
                s_nxt.cnt  = cst_pkg::STAB_W'(1);
            end else if (s_r.cnt != '1) begin
                s_nxt.cnt = s_r.cnt + cst_pkg::STAB_W'(1);
            end
            // cyclic accepts only at the very end of the on-time
            if ((s_nxt.cnt >= need) && (!cyclic || sel_end)) begin
                s_nxt.level = s_nxt.cand;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // in cyclic mode the level only moves on the window's closing tick
    cyclic_edge_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (cyclic && (s_nxt.level != s_r.level)) |-> sel_end)
        else $error("cyclic level changed outside window end");

    // a static level change needs the full stability count behind it
    static_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!cyclic && (s_nxt.level != s_r.level)) |-> (s_nxt.cnt >= need))
        else $error("static level accepted too early");

endmodule

`default_nettype wire

// ---- verif/cst_contacts.sv ----
// switch contacts on the wake pins, fed by a high-side output or by the battery
`timescale 1ns/10ps
`default_nettype none

module cst_contacts (
    // contact state and supply choice
    input  wire logic [2:0] closed,
    input  wire logic [2:0] fed_by_hs,
    input  wire logic [2:0] hs_feed,
    // wake pins
    output logic      [2:0] wake_pin
);
    // pull-down wins while open or unpowered, so no stale level survives
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            wake_pin[i] = closed[i] & (fed_by_hs[i] ? hs_feed[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// ---- verif/tb_cyclic_sense_timers_wake_filter.sv ----
// self-checking bench for the cyclic-sense timers and wake filters
`timescale 1ns/10ps
`default_nettype none

module tb_cyclic_sense_timers_wake_filter;
    logic        clk_sys = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic        soft_rst = 1'b0, restart = 1'b0, en1 = 1'b0, en2 = 1'b0, p1, p2;
    logic [6:0]  addr = 7'h00;
    logic [7:0]  wdata = 8'h00, rd_data;
    logic [11:0] hs_cfg = 12'h4c2;
    logic [3:0]  hs_out;
    logic [2:0]  wake_in, lvl, closed = 3'h0, fed = 3'h0;
    logic [1:0]  evt;
    int          failures = 0, samples_checked = 0;

    always #12.5 clk_sys = ~clk_sys;

    // one tick per clock keeps the 10 ms period affordable
    cst_block #(.TICK_CYCLES(1)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rd_data(rd_data), .soft_reset(soft_rst), .restart_state(restart),
        .first_timer_wake_source_en(en1), .second_timer_wake_source_en(en2),
        .high_side_cfg(hs_cfg), .wake_in(wake_in), .first_timer_pulse(p1),
        .second_timer_pulse(p2), .high_side_output(hs_out), .wake_level(lvl),
        .timer_wake_evt(evt));
    cst_contacts i_contacts (.closed(closed), .fed_by_hs(fed),
        .hs_feed({hs_out[3], hs_out[2], hs_out[0]}), .wake_pin(wake_in));

    // =========================================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // every drive lands 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
        // one idle edge so a following call never drops and raises in one step
        cyc(1);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        addr = a;
        rd_en = 1'b1;
        cyc(1);
        rd_en = 1'b0;
        chk(rd_data, e);
        cyc(1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // =========================================================================
    // scenarios
    task automatic t_regs();
        rd_chk(7'h0c, 8'h00);
        wr(7'h09, 8'hff);
        wr(7'h0c, 8'hff);
        wr(7'h0d, 8'hf7);
        rd_chk(7'h09, 8'h3f);
        rd_chk(7'h0c, 8'h77);
        rd_chk(7'h0d, 8'h77);
        rd_chk(7'h0a, 8'h00);
        restart = 1'b1;
        cyc(1);
        restart = 1'b0;
        rd_chk(7'h09, 8'h3f);
        rd_chk(7'h0d, 8'h00);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        rd_chk(7'h09, 8'h00);
        $display("regs test done");
    endtask
    task automatic t_timer();
        int n = 0;
        wr(7'h0c, 8'h10);
        while (p1 !== 1'b1 && n < 8) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (p1 === 1'b1 && n < 20000) begin
            if (n == 50) chk(hs_out, 4'h9);
            if (n == 99) chk(evt, 2'h0);
            cyc(1);
            n++;
        end
        chk(n, 100);
        while (p1 === 1'b0 && n < 20000) begin
            cyc(1);
            n++;
        end
        chk(n, 10000);
        wr(7'h0c, 8'h60);
        wr(7'h0d, 8'h60);
        cyc(4);
        chk({p1, p2, hs_out}, 6'h3d);
        wr(7'h0c, 8'h00);
        wr(7'h0d, 8'h00);
        cyc(4);
        chk({p1, p2, hs_out}, 6'h00);
        $display("timer test done");
    endtask
    task automatic t_static();
        wr(7'h09, 8'h04);
        closed = 3'h7;
        cyc(15);
        chk(lvl, 3'h0);
        cyc(1);
        chk(lvl, 3'h5);
        cyc(47);
        chk(lvl, 3'h5);
        cyc(1);
        chk(lvl, 3'h7);
        closed = 3'h0;
        cyc(72);
        chk(lvl, 3'h0);
        $display("static test done");
    endtask
    task automatic t_cyclic();
        int c1 = 0, c2 = 0;
        wr(7'h09, 8'h0e);
        fed = 3'h3;
        closed = 3'h3;
        en1 = 1'b1;
        en2 = 1'b1;
        wr(7'h0c, 8'h10);
        wr(7'h0d, 8'h10);
        cyc(60);
        chk(lvl, 3'h0);
        repeat (10000) begin
            c1 += int'(evt[0]);
            c2 += int'(evt[1]);
            cyc(1);
        end
        chk({c1[3:0], c2[3:0]}, 8'h11);
        chk(lvl, 3'h3);
        $display("cyclic test done");
    endtask

    // =========================================================================
    // main sequence and watchdog
    initial begin
        cyc(16);
        reset_n = 1'b1;
        cyc(1);
        t_regs();
        t_timer();
        t_static();
        t_cyclic();
        results();
    end
    initial begin
        #(60000 * 25);
        failures++;
        results();
    end
endmodule
`default_nettype wire
